// ### common/pcm_pkg.sv
// Operation
// - Four serial lines: bit clock, frame sync, data in, three-state data out.
// - Master drives bit clock and frame sync; slave takes both from the codec.
// - Slave bit clock may run up to 16 MHz; codec must not exceed it.
// - Above 12 MHz bit clock, each data burst is at most 32 bits.
// - Master bit clock is programmable between 64 kHz and 6 MHz.
// - Word length per channel 8 to 320 bits, or 640 with one channel.
// - Start position per channel set in bit clocks from frame sync edge.
// - Bit order set per channel and direction; LSB first only up to 24 bits.
// - Receive and transmit word lengths of a channel may differ.
// - Data out is high impedance whenever no word is shifted out.
// - A setting forces data out permanently to high impedance.
// - Data out starts high impedance after power-up.
// - Frame idle periods tolerated in both roles; bit clock rests at 0.
// - Master holds bit clock low from the idle start count onward.
// - Master idle ends at the idle end count; length is end minus start.
// - All data bits precede the idle start; software places idle after data.
// - Rising or falling edge operation; frame sync and data in may be inverted.
// - Falling-edge mode: frame sync sampled on falling, data in on rising edges.
// - Two channels; mu-law, A-law, linear and transparent coding, either role.
// - I2S mode: two slots per frame, left then right, up to 40 and 80 clocks.
// - Full transmit holder: selectable overwrite or discard of new samples.
// - Sample encoding A-law, mu-law 8-bit, linear 8 or 16-bit.
package pcm_pkg;

  localparam int CLK_HZ      = 100_000_000;
  localparam int BCLK_MAX_HZ = 6_000_000;
  localparam int BCLK_MIN_HZ = 64_000;
  localparam int FAST_HZ     = 12_000_000;
  localparam int HALF_MIN_I  = (CLK_HZ + 2 * BCLK_MAX_HZ - 1) / (2 * BCLK_MAX_HZ);
  localparam int HALF_MAX_I  = CLK_HZ / (2 * BCLK_MIN_HZ);
  localparam int FAST_CYC_I  = CLK_HZ / FAST_HZ;

  localparam logic [9:0] HALF_MIN = 10'(HALF_MIN_I);
  localparam logic [9:0] HALF_MAX = 10'(HALF_MAX_I);
  localparam logic [3:0] FAST_CYC = 4'(FAST_CYC_I);

  localparam logic [9:0] LEN_MIN   = 10'h008;
  localparam logic [9:0] LEN_MAX1  = 10'h280;
  localparam logic [9:0] LEN_MAX2  = 10'h140;
  localparam logic [9:0] LEN_FAST  = 10'h020;
  localparam logic [9:0] LSB_MAX   = 10'h018;

  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DIV   = 8'h04;
  localparam logic [7:0] OFS_FRAME = 8'h08;
  localparam logic [7:0] OFS_IDLE  = 8'h0C;
  localparam logic [7:0] OFS_POS0  = 8'h10;
  localparam logic [7:0] OFS_LEN0  = 8'h18;
  localparam logic [7:0] OFS_TX0   = 8'h20;
  localparam logic [7:0] OFS_RX0   = 8'h28;
  localparam logic [7:0] OFS_STAT  = 8'h30;

  localparam int C_EN     = 0;
  localparam int C_MASTER = 1;
  localparam int C_EDGE   = 2;
  localparam int C_FSINV  = 3;
  localparam int C_DINV   = 4;
  localparam int C_HIZ    = 5;
  localparam int C_TWO    = 6;
  localparam int C_I2S    = 7;
  localparam int C_COD    = 8;
  localparam int C_OVF    = 10;
  localparam int C_TXLSB  = 11;
  localparam int C_RXLSB  = 13;
  localparam int S_DROP   = 4;

  localparam logic [14:0] CTRL_RST  = 15'h0020;
  localparam logic [9:0]  DIV_RST   = 10'h032;
  localparam logic [10:0] FRAME_RST = 11'h064;
  localparam logic [9:0]  LEN_RST   = 10'h008;
  localparam logic [7:0]  ALAW_MASK = 8'h55;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    COD_TRANSP = 2'h0,
    COD_LIN    = 2'h1,
    COD_ALAW   = 2'h2,
    COD_MULAW  = 2'h3
  } coding_t;

endpackage

// ### logic/pcm_codec_port.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module pcm_codec_port
  import pcm_pkg::*;
#(
  parameter int SAMPLE_W = 32
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bclk_i,
  output logic             bclk_o,
  output logic             bclk_oe,
  input  wire logic        fsync_i,
  output logic             fsync_o,
  output logic             fsync_oe,
  input  wire logic        din,
  output logic             dout_o,
  output logic             dout_oe
);

  if (SAMPLE_W < 24 || SAMPLE_W > 32)
  begin : g_bad_w
    $error("SAMPLE_W must lie between 24 and 32");
  end

  function automatic logic map_hit(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_STAT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b])
        o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction

  // Clamp keeps a bad setting from running a window past what the pins allow
  function automatic logic [9:0] len_eff(input logic [9:0] l, input logic two, input logic fast);
    logic [9:0] m;
    m = fast ? LEN_FAST : (two ? LEN_MAX2 : LEN_MAX1);
    if (l < LEN_MIN)
      l = LEN_MIN;
    return (l > m) ? m : l;
  endfunction

  // Companding is applied on the low byte only: software supplies log codes
  function automatic logic [SAMPLE_W-1:0] code(input logic [SAMPLE_W-1:0] w, input coding_t c);
    if (c == COD_ALAW)
      w[7:0] = w[7:0] ^ ALAW_MASK;
    else if (c == COD_MULAW)
      w[7:0] = ~w[7:0];
    return w;
  endfunction

  logic [14:0]         ctrl;
  logic [9:0]          half;
  logic [10:0]         frame_len;
  logic [10:0]         idle_start;
  logic [10:0]         idle_end;
  logic [10:0]         pos [2];
  logic [9:0]          tx_len [2];
  logic [9:0]          rx_len [2];
  logic [7:0]          aw_q;
  logic [31:0]         w_q;
  logic [3:0]          s_q;
  logic                aw_full;
  logic                w_full;
  wire  [1:0]          tx_full;
  wire  [1:0]          rx_valid;
  wire  [1:0]          tx_drop;
  wire  [1:0]          tx_win;
  wire  [1:0]          tx_bit;
  wire  [SAMPLE_W-1:0] rx_word [2];

  wire     en     = ctrl[C_EN];
  wire     master = ctrl[C_MASTER];
  wire     two_ch = ctrl[C_TWO];
  coding_t cod;
  assign cod = coding_t'(ctrl[C_COD +: 2]);

  wire wr_go = aw_full & w_full & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0;
      s_q           <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q          <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q          <= s_axi_wdata;
        s_q          <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_hit(aw_q) ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end

  // Configuration store; holder writes and flag clears live with each channel
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      ctrl       <= CTRL_RST;
      half       <= DIV_RST;
      frame_len  <= FRAME_RST;
      idle_start <= 11'h000;
      idle_end   <= 11'h000;
      for (int i = 0; i < 2; i++)
      begin
        pos[i]    <= 11'h000;
        tx_len[i] <= LEN_RST;
        rx_len[i] <= LEN_RST;
      end
    end
    else if (wr_go)
      case (aw_q)
        OFS_CTRL:  ctrl <= 15'(merge(32'(ctrl), w_q, s_q));
        OFS_DIV:
        begin
          logic [9:0] d;
          d = 10'(merge(32'(half), w_q, s_q));
          half <= (d < HALF_MIN) ? HALF_MIN : ((d > HALF_MAX) ? HALF_MAX : d);
        end
        OFS_FRAME: frame_len <= 11'(merge(32'(frame_len), w_q, s_q));
        OFS_IDLE:
        begin
          logic [31:0] v;
          v = merge({5'h0, idle_end, 5'h0, idle_start}, w_q, s_q);
          idle_start <= v[10:0];
          idle_end   <= v[26:16];
        end
        OFS_POS0, OFS_POS0 + 8'h04:
          pos[aw_q[2]] <= 11'(merge(32'(pos[aw_q[2]]), w_q, s_q));
        OFS_LEN0, OFS_LEN0 + 8'h04:
        begin
          logic [31:0] v;
          v = merge({6'h0, rx_len[aw_q[2]], 6'h0, tx_len[aw_q[2]]}, w_q, s_q);
          tx_len[aw_q[2]] <= v[9:0];
          rx_len[aw_q[2]] <= v[25:16];
        end
        default: ;
      endcase

  logic bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, din_s1, din_s2;

  always_ff @(posedge aclk)
    if (!aresetn)
      {bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, din_s1, din_s2} <= 7'h00;
    else
    begin
      bclk_s1 <= bclk_i;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      fs_s1   <= fsync_i;
      fs_s2   <= fs_s1;
      din_s1  <= din;
      din_s2  <= din_s1;
    end

  logic [9:0]  div_cnt;
  logic        phase;
  logic [10:0] timer;
  logic        fs_prev;
  logic        idle;
  logic [3:0]  per_cnt;
  logic        fast;

  // The divider runs through idle so the timer keeps counting bit periods
  wire half_tick = master & en & (div_cnt == half - 10'h001);

  always_ff @(posedge aclk)
    if (!aresetn || !master || !en)
    begin
      div_cnt <= 10'h000;
      phase   <= 1'b0;
    end
    else if (half_tick)
    begin
      div_cnt <= 10'h000;
      phase   <= ~phase;
    end
    else
      div_cnt <= div_cnt + 10'h001;

  wire rise_ev = master ? (half_tick & ~phase) : (bclk_s2 & ~bclk_s3);
  wire fall_ev = master ? (half_tick & phase) : (~bclk_s2 & bclk_s3);
  wire ev_a    = ctrl[C_EDGE] ? fall_ev : rise_ev;
  wire ev_b    = ctrl[C_EDGE] ? rise_ev : fall_ev;

  wire        fs_lvl     = (master ? fsync_o : fs_s2) ^ ctrl[C_FSINV];
  wire        start      = ev_a & fs_lvl & ~fs_prev;
  wire [10:0] next_timer = start ? 11'h000 : ((&timer) ? timer : timer + 11'h001);
  wire        next_idle  = master & (next_timer >= idle_start) & (next_timer < idle_end);
  wire        fs_gen     = (next_timer == frame_len - 11'h001)
                         | (ctrl[C_I2S] & (next_timer < (frame_len >> 1) - 11'h001));

  always_ff @(posedge aclk)
    if (!aresetn || !en)
    begin
      timer   <= 11'h000;
      fs_prev <= 1'b0;
      idle    <= 1'b0;
    end
    else if (ev_a)
    begin
      timer   <= next_timer;
      fs_prev <= fs_lvl;
      idle    <= next_idle;
    end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      bclk_o   <= 1'b0;
      bclk_oe  <= 1'b0;
      fsync_o  <= 1'b0;
      fsync_oe <= 1'b0;
    end
    else
    begin
      bclk_oe  <= master & en;
      fsync_oe <= master & en;
      // Idle is taken from the next timer value so no runt pulse leaks out
      bclk_o   <= master & en & (half_tick ? ~phase : phase)
                & ~(ev_a ? next_idle : idle);
      if (!master || !en)
        fsync_o <= ctrl[C_FSINV];
      else if (ev_a)
        fsync_o <= fs_gen ^ ctrl[C_FSINV];
    end

  // Slave rate watch: a period of FAST_CYC aclk or less is above 12 MHz
  always_ff @(posedge aclk)
    if (!aresetn || master)
    begin
      per_cnt <= 4'h0;
      fast    <= 1'b0;
    end
    else if (rise_ev)
    begin
      per_cnt <= 4'h0;
      fast    <= (per_cnt < FAST_CYC);
    end
    else if (per_cnt != 4'hF)
      per_cnt <= per_cnt + 4'h1;

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic [SAMPLE_W-1:0] hold, shadow, sh, nsh, word;
    logic                full, drop, valid;
    wire        act    = (i == 0) | two_ch;
    wire [9:0]  tl     = len_eff(tx_len[i], two_ch, fast);
    wire [9:0]  rl     = len_eff(rx_len[i], two_ch, fast);
    wire        tx_lsb = ctrl[C_TXLSB + i] & (tl <= LSB_MAX);
    wire        rx_lsb = ctrl[C_RXLSB + i] & (rl <= LSB_MAX);
    wire [10:0] kt     = next_timer - pos[i];
    wire [10:0] kr     = timer - pos[i];
    wire        in_tx  = act & en & (next_timer >= pos[i]) & (kt < {1'b0, tl});
    wire        in_rx  = act & en & (timer >= pos[i]) & (kr < {1'b0, rl});
    wire [10:0] idx    = tx_lsb ? kt : {1'b0, tl} - 11'h001 - kt;
    wire [SAMPLE_W-1:0] src = start ? code(hold, cod) : shadow;
    wire        wr_tx  = wr_go & (aw_q == OFS_TX0 + 8'(4 * i));
    wire        d_in   = din_s2 ^ ctrl[C_DINV];

    assign tx_win[i]  = in_tx;
    assign tx_bit[i]  = (idx < 11'(SAMPLE_W)) ? src[idx[4:0]] : 1'b0;
    assign tx_full[i] = full;
    assign tx_drop[i] = drop;
    assign rx_valid[i] = valid;
    assign rx_word[i] = word;

    always_ff @(posedge aclk)
      if (!aresetn)
      begin
        hold   <= '0;
        shadow <= '0;
        full   <= 1'b0;
        drop   <= 1'b0;
      end
      else
      begin
        if (ev_a && start)
        begin
          shadow <= code(hold, cod);
          full   <= 1'b0;
        end
        if (wr_go && aw_q == OFS_STAT && s_q[0] && w_q[S_DROP + i])
          drop <= 1'b0;
        if (wr_tx && full && !ctrl[C_OVF])
          drop <= 1'b1;
        else if (wr_tx)
        begin
          hold <= SAMPLE_W'(w_q);
          full <= 1'b1;
        end
      end

    always_comb
    begin
      nsh = (kr == 11'h000) ? '0 : sh;
      if (!rx_lsb)
        nsh = {nsh[SAMPLE_W-2:0], d_in};
      else if (kr < 11'(SAMPLE_W))
        nsh[kr[4:0]] = d_in;
    end

    always_ff @(posedge aclk)
      if (!aresetn)
      begin
        sh    <= '0;
        word  <= '0;
        valid <= 1'b0;
      end
      else
      begin
        if (ev_b && in_rx)
          sh <= nsh;
        if (ev_b && in_rx && kr == {1'b0, rl} - 11'h001)
        begin
          word  <= code(nsh, cod);
          valid <= 1'b1;
        end
        else if (rd_go && s_axi_araddr == OFS_RX0 + 8'(4 * i))
          valid <= 1'b0;
      end
  end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      dout_o  <= 1'b0;
      dout_oe <= 1'b0;
    end
    else if (!en || ctrl[C_HIZ])
      dout_oe <= 1'b0;
    else if (ev_a)
    begin
      dout_o  <= |(tx_bit & tx_win);
      dout_oe <= |tx_win;
    end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OK;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= map_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
      case (s_axi_araddr)
        OFS_CTRL:          s_axi_rdata <= 32'(ctrl);
        OFS_DIV:           s_axi_rdata <= 32'(half);
        OFS_FRAME:         s_axi_rdata <= 32'(frame_len);
        OFS_IDLE:          s_axi_rdata <= {5'h0, idle_end, 5'h0, idle_start};
        OFS_POS0:          s_axi_rdata <= 32'(pos[0]);
        OFS_POS0 + 8'h04:  s_axi_rdata <= 32'(pos[1]);
        OFS_LEN0:          s_axi_rdata <= {6'h0, rx_len[0], 6'h0, tx_len[0]};
        OFS_LEN0 + 8'h04:  s_axi_rdata <= {6'h0, rx_len[1], 6'h0, tx_len[1]};
        OFS_RX0:           s_axi_rdata <= 32'(rx_word[0]);
        OFS_RX0 + 8'h04:   s_axi_rdata <= 32'(rx_word[1]);
        OFS_STAT:          s_axi_rdata <= {13'h0, timer, fast, idle, tx_drop, rx_valid, tx_full};
        default:           s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence idle_entry;
    master && en && ev_a && next_idle;
  endsequence

  hiz_force_a:   assert property (ctrl[C_HIZ] |=> !dout_oe)
    else $error("data out driven while forced to high impedance");
  hiz_window_a:  assert property ($rose(dout_oe) |-> $past(ev_a) && $past(|tx_win))
    else $error("data out enabled outside a word window");
  idle_low_a:    assert property (idle_entry |=> !bclk_o [*2])
    else $error("bit clock not low in idle period");
  restart_a:     assert property (start && en |=> timer == 11'h000)
    else $error("frame timer did not restart at frame sync");
  lsb_limit_a:   assert property (g_ch[0].tx_lsb |-> g_ch[0].tl <= LSB_MAX)
    else $error("lsb first used above 24 bits");
  burst_fast_a:  assert property (fast |-> g_ch[0].rl <= LEN_FAST && g_ch[1].tl <= LEN_FAST)
    else $error("burst longer than 32 bits at high clock rate");
  div_range_a:   assert property (half >= HALF_MIN && half <= HALF_MAX)
    else $error("bit clock divider out of range");
  role_pins_a:   assert property (master && en |=> bclk_oe && fsync_oe)
    else $error("master does not drive clock and frame sync");
  slave_pins_a:  assert property (!master |=> !bclk_oe && !fsync_oe)
    else $error("slave drives clock or frame sync");
  len_range_a:   assert property (g_ch[1].tl >= LEN_MIN && g_ch[0].tl <= LEN_MAX1)
    else $error("word length outside 8 to 640");
  idle_end_a:    assert property (idle && ev_a && !next_idle |-> next_timer == idle_end
                                  || next_timer < idle_start)
    else $error("idle ended away from the end count");

endmodule // pcm_codec_port

// ### dv/codec_model.sv
module codec_model (
  input  wire logic       bclk,
  input  wire logic       fsync,
  input  wire logic       dout_o,
  input  wire logic       dout_oe,
  input  wire logic [7:0] word,
  input  wire logic       go,
  output logic            cbclk,
  output logic            cfsync,
  output logic            din,
  output logic [7:0]      got,
  output int              last,
  output int              nf,
  output int              sent
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic busy;
  logic dbit;
  bit   tog;
  assign din = busy ? dbit : tog;
  initial
  begin
    {cbclk, cfsync, dbit, busy} = '0;
    sent = 0;
    forever
    begin
      @(posedge go);
      busy = 1'b1;
      // Clock runs only inside the frame and rests low afterwards
      for (int n = 0; n < 12; n++)
      begin
        cfsync = (n == 0);
        #80 cbclk = 1'b1;
        dbit = (n >= 1 && n <= 8) ? word[8-n] : ~dbit;
        #80 cbclk = 1'b0;
      end
      busy = 1'b0;
      sent++;
    end
  end
  // Sampled on the falling edge, where both device outputs are settled
  always @(negedge bclk)
  begin
    if (dout_oe)
      got <= {got[6:0], dout_o};
    if (fsync)
    begin
      last <= cnt;
      cnt <= 1;
      nf <= nf + 1;
    end
    else
      cnt <= cnt + 1;
  end
  // Undriven data line must not look like held data
  always @(posedge bclk)
    if (!busy)
      tog <= ~tog;
endmodule // codec_model

// ### dv/tb.sv
module tb;
  import pcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, go;
  logic        awr, wrd, bvalid, arr, rvalid, bclk, fsync, din, cbclk, cfsync;
  logic        bclk_o, bclk_oe, fsync_o, fsync_oe, dout_o, dout_oe;
  logic [7:0]  awa, ara, word, got, w;
  logic [31:0] wd, rdata, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, r;
  int          num_errors, checks, oe_cnt, last, nf, sent;
  assign bclk = bclk_oe ? bclk_o : cbclk;
  assign fsync = fsync_oe ? fsync_o : cfsync;
  pcm_codec_port dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rry), .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .fsync_i(fsync),
    .fsync_o(fsync_o), .fsync_oe(fsync_oe), .din(din), .dout_o(dout_o), .dout_oe(dout_oe));
  codec_model codec_u (
    .bclk(bclk), .fsync(fsync), .dout_o(dout_o), .dout_oe(dout_oe), .word(word), .go(go),
    .cbclk(cbclk), .cfsync(cfsync), .din(din), .got(got), .last(last), .nf(nf), .sent(sent));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (dout_oe)
      oe_cnt <= oe_cnt + 1;
  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo();
    num_errors++;
    $display("Error timeout expected answer seen none");
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        return;
      end
    end
    tmo();
  endtask
  // Frames are counted by the codec model, so the bound is in aclk cycles
  task automatic wf(input bit s, input int n);
    int t;
    t = (s ? sent : nf) + n;
    for (int i = 0; i < 30000; i++)
    begin
      @(posedge aclk);
      if ((s ? sent : nf) >= t)
        return;
    end
    tmo();
  endtask
  function automatic logic [7:0] enc(input logic [7:0] v, input int c);
    logic [7:0] x;
    for (int i = 0; i < 8; i++)
      x[i] = v[7-i];
    return c == 4 ? x : c == 3 ? ~v : c == 2 ? v ^ ALAW_MASK : v;
  endfunction
  initial
  begin
    {awv, wv, bry, arv, rry, go, aresetn} = '0;
    {awa, ara, word, wd} = '0;
    ws = 4'hF;
    void'($urandom(32'h625FD791));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl", 32'(CTRL_RST), d);
    chk("dout_oe", 0, dout_oe);
    rd(OFS_DIV);
    chk("div", 32'(DIV_RST), d);
    rd(8'hFC);
    chk("resp", 32'(RESP_ERR), 32'(r));
    wr(8'hFC, 32'h0);
    chk("bresp err", 32'(RESP_ERR), 32'(r));
    wr(OFS_DIV, 1);
    chk("bresp ok", 32'(RESP_OK), 32'(r));
    rd(OFS_DIV);
    chk("div lo", 32'(HALF_MIN), d);
    wr(OFS_DIV, 32'h3E8);
    rd(OFS_DIV);
    chk("div hi", 32'(HALF_MAX), d);
    $display("test registers done");
    wr(OFS_CTRL, 0);
    wr(OFS_TX0, $urandom);
    wr(OFS_TX0, $urandom);
    rd(OFS_STAT);
    chk("drop", 2'b11, {d[4], d[0]});
    wr(OFS_STAT, 32'h10);
    wr(OFS_CTRL, 32'h400);
    wr(OFS_TX0, $urandom);
    rd(OFS_STAT);
    chk("overwrite", 2'b01, {d[4], d[0]});
    $display("test overflow done");
    wr(OFS_DIV, 9);
    wr(OFS_FRAME, 20);
    wr(OFS_POS0, 2);
    wr(OFS_IDLE, 32'h0010000C);
    wr(OFS_CTRL, 32'h23);
    wf(0, 3);
    chk("hiz", 0, oe_cnt);
    chk("edges", 16, last);
    chk("bclk_oe", 1, bclk_oe);
    chk("fsync_oe", 1, fsync_oe);
    // Last pass uses transparent coding with LSB-first transmit
    for (int c = 0; c < 5; c++)
    begin
      w = 8'($urandom);
      wr(OFS_TX0, w);
      wr(OFS_CTRL, c == 4 ? 32'h803 : 32'h3 | (c << 8));
      wf(0, 3);
      chk("tx", enc(w, c), got);
    end
    $display("test master done");
    // Disabling first clears the frame state left over from the master role
    wr(OFS_CTRL, 0);
    wr(OFS_POS0, 1);
    for (int k = 0; k < 3; k++)
    begin
      // Second pass receives LSB first, third inverts the data line
      wr(OFS_CTRL, k == 1 ? 32'h2001 : (k == 2 ? 32'h11 : 32'h1));
      word <= 8'($urandom);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      wf(1, 1);
      rd(OFS_STAT);
      chk("rx_valid", 1, d[2]);
      rd(OFS_RX0);
      chk("rx", k == 1 ? enc(word, 4) : word ^ {8{k == 2}}, d[7:0]);
      rd(OFS_STAT);
      chk("rx clear", 0, d[2]);
      chk("slave oe", 0, {bclk_oe, fsync_oe});
    end
    $display("test slave done");
    stop_test();
  end
endmodule // tb
